// ===== disp_mode_pkg.sv
// Constants and types shared by the display mode command block
package disp_mode_pkg;

    // Command codes taken from the host command byte
    localparam logic [7:0] SOFT_RESET_CMD        = 8'h01;
    localparam logic [7:0] PARTIAL_ON_CMD        = 8'h12;
    localparam logic [7:0] NORMAL_DISPLAY_ON_CMD = 8'h13;
    localparam logic [7:0] INVERT_OFF_CMD        = 8'h20;
    localparam logic [7:0] INVERT_ON_CMD         = 8'h21;

    // Register byte offsets
    localparam logic [7:0] STATUS_OFFSET    = 8'h00;
    localparam logic [7:0] CTRL_OFFSET      = 8'h04;
    localparam logic [7:0] CMD_OFFSET       = 8'h08;
    localparam logic [7:0] CMD_COUNT_OFFSET = 8'h0C;

    // Status register field positions
    localparam int STATUS_NORMAL_BIT        = 0;
    localparam int STATUS_PARTIAL_BIT       = 1;
    localparam int STATUS_INVERT_BIT        = 2;
    localparam int STATUS_ACT_NORMAL_BIT    = 3;
    localparam int STATUS_ACT_INVERT_BIT    = 4;

    // Control register field positions
    localparam int CTRL_SOFT_RESET_BIT      = 0;
    localparam int CTRL_FRAME_SYNC_BIT      = 1;

    // Reset values
    localparam logic       NORMAL_RESET     = 1'b1;
    localparam logic       INVERT_RESET     = 1'b0;
    localparam logic       FRAME_SYNC_RESET = 1'b1;
    localparam logic [7:0] LAST_CMD_RESET   = 8'h00;
    localparam logic [7:0] CMD_COUNT_RESET  = 8'h00;

    // Widths
    localparam int PIXEL_WIDTH   = 18;
    localparam int CMD_WIDTH     = 8;

    // Display mode pair: normal/partial and inversion
    typedef struct packed {
        logic normal;
        logic invert;
    } mode_t;

    // One pixel word with its valid flag
    typedef struct packed {
        logic                   valid;
        logic [PIXEL_WIDTH-1:0] data;
    } pixel_t;

    localparam mode_t MODE_RESET = '{normal: NORMAL_RESET,
                                     invert: INVERT_RESET};

endpackage

// ===== disp_mode_cmd.sv
// Display mode and inversion command decoder with APB status and control
//
// Functional notes
// - Normal-display command restores full-screen mode
// - Normal mode on clears partial mode
// - Only partial-on command leaves normal mode
// - Normal-display ignored when already normal
// - Any reset restores normal mode, partial off
// - Inversion-off passes memory pixels unmodified
// - Inversion never touches frame memory contents
// - Inversion commands change no other flag
// - Inversion-off ignored when already off
// - Inversion-on enters inversion until inversion-off
// - Inversion flips every pixel bit to panel
// - Inversion-on ignored when already on
// - Any reset leaves inversion off
// - Commands accepted in every power mode
// - Partial-on command enters partial mode
`timescale 1ns/1ps

module disp_mode_cmd
    import disp_mode_pkg::*;
(
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [7:0]             paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    // Host command pins, asynchronous to pclk
    input  wire logic                   data_command_select,
    input  wire logic                   read_strobe_n,
    input  wire logic                   write_strobe_n,
    input  wire logic [CMD_WIDTH-1:0]   data_lines,
    // Pixel path from frame memory to panel
    input  wire logic                   frame_start,
    input  wire pixel_t                 pixel_in,
    output pixel_t                      pixel_out,
    // Mode state seen by the panel timing logic
    output logic                        partial_mode,
    output logic                        invert_mode
);

    // Two-flop synchronisers for the host pins; stage one feeds only stage
    // two, and a third flop of the strobe gives the rising edge
    logic [CMD_WIDTH+2:0] pin_meta_reg;
    logic [CMD_WIDTH+2:0] pin_sync_reg;
    logic                 wr_prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta_reg <= '1;
            pin_sync_reg <= '1;
            wr_prev_reg  <= 1'b1;
        end else begin
            pin_meta_reg <= {write_strobe_n, read_strobe_n,
                             data_command_select, data_lines};
            pin_sync_reg <= pin_meta_reg;
            wr_prev_reg  <= pin_sync_reg[CMD_WIDTH+2];
        end
    end

    logic                 wr_sync;
    logic                 rd_sync;
    logic                 dc_sync;
    logic [CMD_WIDTH-1:0] byte_sync;
    logic                 pin_cmd_valid;

    assign wr_sync   = pin_sync_reg[CMD_WIDTH+2];
    assign rd_sync   = pin_sync_reg[CMD_WIDTH+1];
    assign dc_sync   = pin_sync_reg[CMD_WIDTH];
    assign byte_sync = pin_sync_reg[CMD_WIDTH-1:0];

    // command byte on rising write strobe
    // Only a command byte counts; parameter bytes belong to other blocks
    assign pin_cmd_valid = !wr_prev_reg && wr_sync && !dc_sync && rd_sync;

    // APB decode; zero wait unless a pin command claims the decoder
    logic apb_access;
    logic apb_write;
    logic apb_read;
    logic addr_hit;

    assign apb_access = psel && penable;
    assign addr_hit   = (paddr == STATUS_OFFSET) || (paddr == CTRL_OFFSET) ||
                        (paddr == CMD_OFFSET) || (paddr == CMD_COUNT_OFFSET);
    // A pin command and an APB command write would collide in one cycle,
    // so the APB write is held off for that cycle instead of being lost
    assign pready     = !(pin_cmd_valid && pwrite && (paddr == CMD_OFFSET));
    assign pslverr    = apb_access && !addr_hit;
    assign apb_write  = apb_access && pready && pwrite && addr_hit;
    assign apb_read   = apb_access && !pwrite && addr_hit;

    // Select the command source for this cycle
    logic                 cmd_valid;
    logic [CMD_WIDTH-1:0] cmd_code;

    always_comb begin
        cmd_valid = 1'b0;
        cmd_code  = byte_sync;
        if (pin_cmd_valid) begin
            cmd_valid = 1'b1;
        end else if (apb_write && (paddr == CMD_OFFSET)) begin
            cmd_valid = 1'b1;
            cmd_code  = pwdata[CMD_WIDTH-1:0];
        end
    end

    // Control register state
    logic frame_sync_reg;
    logic frame_sync_next;
    logic soft_reset_req;

    assign soft_reset_req = apb_write && (paddr == CTRL_OFFSET) &&
                            pwdata[CTRL_SOFT_RESET_BIT];

    always_comb begin
        frame_sync_next = frame_sync_reg;
        if (apb_write && (paddr == CTRL_OFFSET)) begin
            frame_sync_next = pwdata[CTRL_FRAME_SYNC_BIT];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame_sync_reg <= FRAME_SYNC_RESET;
        end else begin
            frame_sync_reg <= frame_sync_next;
        end
    end

    // Requested mode state, updated by a completed command byte or a control register soft reset
    mode_t                mode_reg;
    mode_t                mode_next;
    logic [CMD_WIDTH-1:0] last_cmd_reg;
    logic [CMD_WIDTH-1:0] last_cmd_next;
    logic [7:0]           cmd_count_reg;
    logic [7:0]           cmd_count_next;

    always_comb begin
        mode_next      = mode_reg;
        last_cmd_next  = last_cmd_reg;
        cmd_count_next = cmd_count_reg;
        if (cmd_valid) begin
            last_cmd_next  = cmd_code;
            cmd_count_next = cmd_count_reg + 8'h01;
            case (cmd_code)
                SOFT_RESET_CMD: begin
                    mode_next = MODE_RESET;
                end
                PARTIAL_ON_CMD: begin
                    mode_next.normal = 1'b0;
                end
                // setting a set bit changes nothing
                NORMAL_DISPLAY_ON_CMD: begin
                    mode_next.normal = 1'b1;
                end
                INVERT_OFF_CMD: begin
                    mode_next.invert = 1'b0;
                end
                INVERT_ON_CMD: begin
                    mode_next.invert = 1'b1;
                end
                default: begin
                    mode_next = mode_reg;
                end
            endcase
        end
        if (soft_reset_req) begin
            mode_next = MODE_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_reg      <= MODE_RESET;
            last_cmd_reg  <= LAST_CMD_RESET;
            cmd_count_reg <= CMD_COUNT_RESET;
        end else begin
            mode_reg      <= mode_next;
            last_cmd_reg  <= last_cmd_next;
            cmd_count_reg <= cmd_count_next;
        end
    end

    // Active mode seen by the panel; with frame sync on it waits for the
    // frame start so a change never tears a frame mid-scan
    mode_t active_reg;
    mode_t active_next;

    always_comb begin
        active_next = active_reg;
        if (!frame_sync_reg || frame_start) begin
            active_next = mode_reg;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            active_reg <= MODE_RESET;
        end else begin
            active_reg <= active_next;
        end
    end

    assign partial_mode = !active_reg.normal;
    assign invert_mode  = active_reg.invert;

    // Pixel path: one cycle of latency, memory side is only read
    pixel_t pixel_reg;
    pixel_t pixel_next;

    always_comb begin
        pixel_next.valid = pixel_in.valid;
        pixel_next.data  = pixel_in.data;
        if (active_reg.invert) begin
            pixel_next.data = ~pixel_in.data;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pixel_reg <= '0;
        end else begin
            pixel_reg <= pixel_next;
        end
    end

    assign pixel_out = pixel_reg;

    // Read data mux; unmapped and idle cycles return zero
    logic [31:0] rdata_mux;

    always_comb begin
        rdata_mux = 32'h0000_0000;
        if (apb_read) begin
            case (paddr)
                STATUS_OFFSET: begin
                    rdata_mux[STATUS_NORMAL_BIT]     = mode_reg.normal;
                    rdata_mux[STATUS_PARTIAL_BIT]    = !mode_reg.normal;
                    rdata_mux[STATUS_INVERT_BIT]     = mode_reg.invert;
                    rdata_mux[STATUS_ACT_NORMAL_BIT] = active_reg.normal;
                    rdata_mux[STATUS_ACT_INVERT_BIT] = active_reg.invert;
                end
                CTRL_OFFSET: begin
                    rdata_mux[CTRL_FRAME_SYNC_BIT] = frame_sync_reg;
                end
                CMD_OFFSET: begin
                    rdata_mux[CMD_WIDTH-1:0] = last_cmd_reg;
                end
                CMD_COUNT_OFFSET: begin
                    rdata_mux[7:0] = cmd_count_reg;
                end
                default: begin
                    rdata_mux = 32'h0000_0000;
                end
            endcase
        end
    end

    assign prdata = rdata_mux;

endmodule

// ===== host_cmd_model.sv
// Host side model that writes command bytes on the pins
`timescale 1ns/1ps
module host_cmd_model (
    // Pacing clock
    input  wire logic pclk,
    // Command pins
    output logic       data_command_select,
    output logic       read_strobe_n,
    output logic       write_strobe_n,
    output logic [7:0] data_lines
);
    // Idle pins: strobes high
    initial begin
        data_command_select = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        data_lines = 8'h00;
    end
    // one byte, no parameters
    // Four cycles each way, more than the two stage sync needs
    task automatic send(input logic [7:0] code, input logic dcx);
        @(posedge pclk);
        data_command_select <= dcx;
        data_lines <= code;
        write_strobe_n <= 1'b0;
        repeat (4) @(posedge pclk);
        write_strobe_n <= 1'b1;
        repeat (4) @(posedge pclk);
        // Released lines turn over so stale data is never trusted
        data_lines <= ~code;
    endtask
endmodule

// ===== disp_mode_cmd_asserts.sv
// Port level checks of the display mode command block
`timescale 1ns/1ps
module disp_mode_cmd_asserts
    import disp_mode_pkg::*;
(
    // Clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // APB
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Host pins
    input wire logic        data_command_select,
    input wire logic        read_strobe_n,
    input wire logic        write_strobe_n,
    input wire logic [7:0]  data_lines,
    // Pixel path and modes
    input wire logic        frame_start,
    input wire pixel_t      pixel_in,
    input wire pixel_t      pixel_out,
    input wire logic        partial_mode,
    input wire logic        invert_mode
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic acc;
    logic hit;
    // Access phase and decode of the four mapped words
    assign acc = psel && penable;
    assign hit = paddr inside {STATUS_OFFSET, CTRL_OFFSET, CMD_OFFSET,
                               CMD_COUNT_OFFSET};
    a_pix_invert: assert property (
        pixel_in.valid ##1 $stable(invert_mode) |-> pixel_out.data ==
        (invert_mode ? ~$past(pixel_in.data) : $past(pixel_in.data)))
        else $error("pixel data path wrong");
    a_pix_valid: assert property (
        1'b1 |=> pixel_out.valid == $past(pixel_in.valid))
        else $error("pixel valid not passed");
    a_reset_mode: assert property (
        $rose(presetn) |-> !partial_mode && !invert_mode)
        else $error("modes not default after reset");
    a_frame_apply: assert property (
        $changed(invert_mode) || $changed(partial_mode)
        |-> $past(frame_start) || $past(frame_start, 2))
        else $error("mode changed off frame boundary");
    a_bad_addr: assert property (
        acc && !hit |-> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    a_good_addr: assert property (acc && hit |-> !pslverr)
        else $error("mapped access refused");
    a_ready_high: assert property (
        acc && !(pwrite && paddr == CMD_OFFSET) |-> pready)
        else $error("unexpected wait state");
    a_cmd_wait: assert property (
        acc && pwrite && paddr == CMD_OFFSET && !pready |=> pready)
        else $error("command write waited too long");
    a_rdata_idle: assert property (!(acc && !pwrite) |-> prdata == 0)
        else $error("read data outside read access");
    // Main scenarios reached
    c_invert: cover property (pixel_in.valid && invert_mode);
    c_partial: cover property ($rose(partial_mode));
    c_error: cover property (acc && pslverr);
endmodule
bind disp_mode_cmd disp_mode_cmd_asserts chk_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr),
    .data_command_select(data_command_select),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n),
    .data_lines(data_lines), .frame_start(frame_start),
    .pixel_in(pixel_in), .pixel_out(pixel_out),
    .partial_mode(partial_mode), .invert_mode(invert_mode));

// ===== testbench.sv
// Self checking bench for the display mode command block
`timescale 1ns/1ps
module testbench;
    import disp_mode_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, frame_start;
    logic        pready, pslverr, dcx, rdn, wrn, rerr;
    logic [7:0]  paddr, dl;
    logic [31:0] pwdata, prdata, rdata;
    pixel_t      pixel_in, pixel_out;
    logic        partial_mode, invert_mode;
    int          error_cnt, checks, cyc;

    disp_mode_cmd dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .data_command_select(dcx), .read_strobe_n(rdn),
        .write_strobe_n(wrn), .data_lines(dl), .frame_start(frame_start),
        .pixel_in(pixel_in), .pixel_out(pixel_out),
        .partial_mode(partial_mode), .invert_mode(invert_mode));
    host_cmd_model host_u (.pclk(pclk), .data_command_select(dcx),
        .read_strobe_n(rdn), .write_strobe_n(wrn), .data_lines(dl));

    task automatic end_of_test();
        if (error_cnt == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, e);
        checks++;
        if (s !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h seen %h", nm, e, s);
        end
    endtask

    // One APB transfer; idle cycle first so psel never flips in a step
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rdata = prdata;
        rerr = pslverr;
        if (n >= 16) begin
            error_cnt++;
            end_of_test();
        end
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Pin command, frame boundary, then status and pixel path
    task automatic step(input logic [7:0] c, input logic x, n, i);
        host_u.send(c, x);
        repeat (4) @(posedge pclk);
        frame_start <= 1'b1;
        @(posedge pclk);
        frame_start <= 1'b0;
        repeat (3) @(posedge pclk);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk("status", rdata, {27'h0, i, n, i, !n, n});
        chk("partial", partial_mode, !n);
        pixel_in <= '{valid: 1'b1, data: 18'h2_A5C3};
        @(posedge pclk);
        pixel_in <= '0;
        #1;
        // XOR keeps the expected word 18 bits wide in a 32 bit compare
        chk("pixel", pixel_out.data, 18'h2_A5C3 ^ {18{i}});
    endtask

    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    // Hang guard, far above the expected run length
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            end_of_test();
        end
    end

    initial begin
        {presetn, psel, penable, pwrite, frame_start} = '0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        pixel_in = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk("reset status", rdata, 32'h0000_0009);
        step(NORMAL_DISPLAY_ON_CMD, 1'b0, 1'b1, 1'b0);
        step(PARTIAL_ON_CMD, 1'b0, 1'b0, 1'b0);
        step(INVERT_ON_CMD, 1'b0, 1'b0, 1'b1);
        step(INVERT_ON_CMD, 1'b0, 1'b0, 1'b1);
        step(NORMAL_DISPLAY_ON_CMD, 1'b1, 1'b0, 1'b1);
        step(NORMAL_DISPLAY_ON_CMD, 1'b0, 1'b1, 1'b1);
        step(INVERT_OFF_CMD, 1'b0, 1'b1, 1'b0);
        step(INVERT_OFF_CMD, 1'b0, 1'b1, 1'b0);
        step(PARTIAL_ON_CMD, 1'b0, 1'b0, 1'b0);
        step(INVERT_ON_CMD, 1'b0, 1'b0, 1'b1);
        step(SOFT_RESET_CMD, 1'b0, 1'b1, 1'b0);
        apb(1'b0, CMD_COUNT_OFFSET, 32'h0000_0000);
        chk("count", rdata, 32'h0000_000A);
        apb(1'b1, CMD_OFFSET, 32'h0000_0021);
        apb(1'b1, CTRL_OFFSET, 32'h0000_0003);
        apb(1'b0, STATUS_OFFSET, 32'h0000_0000);
        chk("soft reset", rdata & 32'h0000_0007, 32'h0000_0001);
        apb(1'b0, CMD_OFFSET, 32'h0000_0000);
        chk("last cmd", rdata, 32'h0000_0021);
        apb(1'b0, 8'h10, 32'h0000_0000);
        chk("unmapped data", rdata, 32'h0000_0000);
        chk("unmapped err", {31'h0, rerr}, 32'h0000_0001);
        end_of_test();
    end
endmodule
